// file: hdl/grouped_interrupt_expander.sv
`timescale 1ns/1ps
// What this block does
// - 96 sources in 12 groups of eight
// - one writable 32-bit vector per source
// - unmultiplexed lines pass to core through one register stage
// - per group 8-bit flag and enable
// - one acknowledge bit per group gates forwarding
// - request sets flag regardless of enable
// - flag, enable, no ack raise group line
// - set ack holds requests back until cleared
// - fetch returns best pending, else source one
// - fetch with the table enabled clears the served source flag
// - table enable bit zero gates vector supply
module grouped_interrupt_expander
  import expander_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // peripheral request levels, index = group*8 + source
  input  wire logic [SOURCE_COUNT-1:0] src_req,
  // unmultiplexed requests and their copy toward the core
  input  wire logic [PASS_COUNT-1:0]   pass_req,
  output      logic [PASS_COUNT-1:0]   pass_line,
  // core interrupt lines, bit g = group g
  output      logic [GROUP_COUNT-1:0]  core_interrupt_line,
  // software: group enable write
  input  wire logic                    enable_wr,
  input  wire logic [GROUP_SEL_W-1:0]  enable_group,
  input  wire logic [GROUP_WIDTH-1:0]  enable_wdata,
  // software: acknowledge clear, one bit per group
  input  wire logic [GROUP_COUNT-1:0]  ack_clear,
  // software: control register
  input  wire logic                    ctrl_wr,
  input  wire logic [7:0]              ctrl_wdata,
  // software: vector table write
  input  wire logic                    vec_wr,
  input  wire logic [VEC_ADDR_W-1:0]   vec_waddr,
  input  wire logic [VECTOR_WIDTH-1:0] vec_wdata,
  // core vector fetch
  input  wire logic                    fetch_req,
  input  wire logic [GROUP_SEL_W-1:0]  fetch_group,
  output      logic                    fetch_valid,
  output      logic [VECTOR_WIDTH-1:0] fetch_vector,
  output      logic [SRC_SEL_W-1:0]    fetch_source,
  // status views
  output      logic [SOURCE_COUNT-1:0] group_flag_reg,
  output      logic [SOURCE_COUNT-1:0] group_enable_reg,
  output      logic [GROUP_COUNT-1:0]  group_ack_reg,
  output      logic                    vector_table_enable
);
  logic [SOURCE_COUNT-1:0] src_prev_reg;        // last request level
  logic [SOURCE_COUNT-1:0] src_rise;            // new requests this cycle
  logic [SOURCE_COUNT-1:0] fetch_clr;           // flag cleared by fetch
  logic [SOURCE_COUNT-1:0] flag_next;
  logic [SOURCE_COUNT-1:0] enable_next;
  logic [GROUP_COUNT-1:0]  ack_set;             // set by vector delivery
  logic [GROUP_COUNT-1:0]  ack_next;
  logic [GROUP_COUNT-1:0]  line_next;
  logic [GROUP_WIDTH-1:0]  sel_pend;            // pending bits of fetched group
  logic [SRC_SEL_W-1:0]    sel_src;             // winner inside group
  logic [VEC_ADDR_W-1:0]   sel_index;           // winner table index
  logic                    fetch_ok;            // fetch request that group indexes
  logic                    fetch_go;            // fetch served from the table
  logic                    stage1_reg;          // read issued last cycle
  logic                    stage1_hit_reg;      // table was enabled at take
  logic [SRC_SEL_W-1:0]    stage1_src_reg;

  vector_mem_if vmem ();

  vector_table_mem u_table (
    .clk (clk),
    .bus (vmem.mem)
  );

  // lowest numbered source wins; none pending falls back to source one
  function automatic logic [SRC_SEL_W-1:0] pick(input logic [GROUP_WIDTH-1:0] p);
    logic [SRC_SEL_W-1:0] r;
    r = '0;
    for (int i = GROUP_WIDTH - 1; i >= 0; i--)
      if (p[i])
        r = SRC_SEL_W'(i);
    return r;
  endfunction : pick

  // only a rising request sets the flag, so a level still held
  // by the peripheral does not refill a flag that fetch just cleared
  assign src_rise  = src_req & ~src_prev_reg;
  assign fetch_ok  = fetch_req && (fetch_group < GROUP_SEL_W'(GROUP_COUNT));
  assign fetch_go  = fetch_ok && vector_table_enable;
  assign sel_pend  = fetch_ok ?
    (group_flag_reg[fetch_group*GROUP_WIDTH +: GROUP_WIDTH] &
     group_enable_reg[fetch_group*GROUP_WIDTH +: GROUP_WIDTH]) : '0;
  assign sel_src   = pick(sel_pend);
  assign sel_index = VEC_ADDR_W'(fetch_group * GROUP_WIDTH) + VEC_ADDR_W'(sel_src);
  assign fetch_clr = fetch_go ? (SOURCE_COUNT'(1) << sel_index) : '0;
  assign ack_set   = fetch_go ? (GROUP_COUNT'(1) << fetch_group) : '0;

  // new request wins over the fetch clear in the same cycle
  assign flag_next = (group_flag_reg & ~fetch_clr) | src_rise;
  // delivery set wins over a software clear in the same cycle
  assign ack_next  = (group_ack_reg & ~ack_clear) | ack_set;

  // table wiring: writes pass straight, reads follow the winner
  assign vmem.wr_en   = vec_wr;
  assign vmem.wr_addr = vec_waddr;
  assign vmem.wr_data = vec_wdata;
  assign vmem.rd_addr = sel_index;

  // per group: enable write and line request
  for (genvar g = 0; g < GROUP_COUNT; g++)
  begin : g_group
    logic hit;
    assign hit = enable_wr && (enable_group == GROUP_SEL_W'(g));
    assign enable_next[g*GROUP_WIDTH +: GROUP_WIDTH] = hit ? enable_wdata :
      group_enable_reg[g*GROUP_WIDTH +: GROUP_WIDTH];
    // any flagged and enabled source, held back while acknowledged
    assign line_next[g] = |(group_flag_reg[g*GROUP_WIDTH +: GROUP_WIDTH] &
      group_enable_reg[g*GROUP_WIDTH +: GROUP_WIDTH]) & ~group_ack_reg[g];
  end

  // flag, enable, acknowledge and control state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      src_prev_reg        <= FLAG_RESET;
      group_flag_reg      <= FLAG_RESET;
      group_enable_reg    <= ENABLE_RESET;
      group_ack_reg       <= ACK_RESET;
      vector_table_enable <= VTE_RESET;
    end
    else
    begin
      src_prev_reg     <= src_req;
      group_flag_reg   <= flag_next;
      group_enable_reg <= enable_next;
      group_ack_reg    <= ack_next;
      if (ctrl_wr)
        vector_table_enable <= ctrl_wdata[VTE_BIT];
    end
  end

  // lines toward the core, one register stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      core_interrupt_line <= '0;
      pass_line           <= '0;
    end
    else
    begin
      core_interrupt_line <= line_next;
      pass_line           <= pass_req;
    end
  end

  // fetch pipeline: take, table read, answer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_reg     <= 1'b0;
      stage1_hit_reg <= 1'b0;
      stage1_src_reg <= '0;
      fetch_valid    <= 1'b0;
      fetch_vector   <= VECTOR_NONE;
      fetch_source   <= '0;
    end
    else
    begin
      stage1_reg     <= fetch_req;
      stage1_hit_reg <= fetch_go;
      stage1_src_reg <= sel_src;
      fetch_valid    <= stage1_reg;
      fetch_source   <= stage1_src_reg;
      // disabled table answers with a null vector
      fetch_vector   <= stage1_hit_reg ? vmem.rd_data : VECTOR_NONE;
    end
  end

  chk_flag_on_rise: assert property (@(posedge clk) disable iff (rst)
    |src_rise |=> ((group_flag_reg & $past(src_rise)) == $past(src_rise)))
    else $error("new request did not set its flag");
  // judged from the flag, enable and ack registers, not from line_next
  chk_line_raised: assert property (@(posedge clk) disable iff (rst)
    |(group_flag_reg[23:16] & group_enable_reg[23:16]) && !group_ack_reg[2]
      |=> core_interrupt_line[2])
    else $error("pending unacknowledged group line not raised");
  chk_ack_blocks: assert property (@(posedge clk) disable iff (rst)
    ##1 ((core_interrupt_line & $past(group_ack_reg)) == '0))
    else $error("line raised while group acknowledged");
  chk_fetch_clears: assert property (@(posedge clk) disable iff (rst)
    fetch_go && !src_rise[sel_index] |=> !group_flag_reg[$past(sel_index)])
    else $error("served flag not cleared");
  chk_ack_on_fetch: assert property (@(posedge clk) disable iff (rst)
    fetch_go |=> group_ack_reg[$past(fetch_group)])
    else $error("acknowledge not set by delivery");
  chk_fetch_winner: assert property (@(posedge clk) disable iff (rst)
    fetch_req |=> ##1 fetch_valid && fetch_source == $past(sel_src, 2))
    else $error("fetch answer late or wrong source");
  chk_disabled_null: assert property (@(posedge clk) disable iff (rst)
    fetch_req && !vector_table_enable |=> ##1 fetch_vector == VECTOR_NONE)
    else $error("vector supplied while table disabled");
  chk_pass_through: assert property (@(posedge clk) disable iff (rst)
    ##1 pass_line == $past(pass_req))
    else $error("pass-through line mismatch");
  chk_enable_write: assert property (@(posedge clk) disable iff (rst)
    enable_wr && enable_group == 4'h2 |=> group_enable_reg[23:16] == $past(enable_wdata))
    else $error("enable write lost");
  chk_ack_held: assert property (@(posedge clk) disable iff (rst)
    group_ack_reg[2] && !ack_clear[2] |=> group_ack_reg[2])
    else $error("acknowledge cleared without software");

  cov_fetch_hit: cover property (@(posedge clk) disable iff (rst) fetch_go ##2 fetch_valid);
  cov_held_back: cover property (@(posedge clk) disable iff (rst)
    group_ack_reg[2] && |(group_flag_reg[23:16] & group_enable_reg[23:16]) ##1 ack_clear[2]);
  cov_empty_fetch: cover property (@(posedge clk) disable iff (rst) fetch_go && sel_pend == '0);
endmodule : grouped_interrupt_expander

// file: hdl/expander_pkg.sv
package expander_pkg;
  localparam int GROUP_COUNT   = 12;     // core interrupt lines fed by groups
  localparam int GROUP_WIDTH   = 8;      // sources per group
  localparam int SOURCE_COUNT  = 96;     // total multiplexed sources
  localparam int VECTOR_WIDTH  = 32;     // one vector word per source
  localparam int VEC_ADDR_W    = 7;      // index into the vector table
  localparam int GROUP_SEL_W   = 4;      // group number 0..11
  localparam int SRC_SEL_W     = 3;      // source number 0..7 inside a group
  localparam int PASS_COUNT    = 4;      // lines 13, 14, realtime os, datalog
  localparam int FETCH_LATENCY = 2;      // cycles from fetch request to vector
  localparam logic [SOURCE_COUNT-1:0] FLAG_RESET   = '0;
  localparam logic [SOURCE_COUNT-1:0] ENABLE_RESET = '0;
  localparam logic [GROUP_COUNT-1:0]  ACK_RESET    = '0;
  localparam logic                    VTE_RESET    = 1'b0;
  localparam int                      VTE_BIT      = 0;  // control bit position
  localparam logic [VECTOR_WIDTH-1:0] VECTOR_NONE  = 32'h0000_0000;
endpackage : expander_pkg

// file: hdl/vector_mem_if.sv
`timescale 1ns/1ps
interface vector_mem_if;
  import expander_pkg::*;
  logic                    wr_en;   // table write strobe
  logic [VEC_ADDR_W-1:0]   wr_addr; // table write index
  logic [VECTOR_WIDTH-1:0] wr_data; // table write word
  logic [VEC_ADDR_W-1:0]   rd_addr; // fetch index, read every cycle
  logic [VECTOR_WIDTH-1:0] rd_data; // registered read word
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : vector_mem_if

// file: hdl/vector_table_mem.sv
`timescale 1ns/1ps
module vector_table_mem
  import expander_pkg::*;
(
  // clock
  input wire logic   clk,
  // table ports
  vector_mem_if.mem  bus
);
  // storage, no reset: software fills it before enabling fetches
  logic [VECTOR_WIDTH-1:0] table_mem [SOURCE_COUNT];
  logic [VECTOR_WIDTH-1:0] rd_data_reg;

  assign bus.rd_data = rd_data_reg;

  // writes accepted in any cycle, even during a fetch
  always_ff @(posedge clk)
  begin
    if (bus.wr_en)
      table_mem[bus.wr_addr] <= bus.wr_data;
  end

  // read data come out of a register; old word on same-address collision
  always_ff @(posedge clk)
  begin
    rd_data_reg <= table_mem[bus.rd_addr];
  end
endmodule : vector_table_mem

// file: bench/core_model.sv
`timescale 1ns/1ps
module core_model
  import expander_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // requests from the expander
  input  wire logic [GROUP_COUNT-1:0] core_interrupt_line,
  // bench hook: fetch a group with nothing flagged
  input  wire logic                   go,
  input  wire logic [GROUP_SEL_W-1:0] go_group,
  // vector fetch
  output      logic                   fetch_req,
  output      logic [GROUP_SEL_W-1:0] fetch_group,
  input  wire logic                   fetch_valid,
  // core-side enables and debug state
  input  wire logic [GROUP_COUNT-1:0] core_line_enable_reg,
  input  wire logic [GROUP_COUNT-1:0] debug_line_enable_reg,
  input  wire logic                   debug_halt
);
  logic [GROUP_COUNT-1:0] line_flag_reg;   // latched line requests
  logic [GROUP_COUNT-1:0] line_q;          // last line level
  logic                   global_mask_bit; // mask held while servicing
  logic                   fetch_wait_reg;  // one fetch outstanding at a time
  logic [GROUP_COUNT-1:0] serviceable;     // latched lines the core may take
  logic                   start;           // begin servicing this cycle
  logic [GROUP_SEL_W-1:0] pick_line;       // line chosen for service
  // lowest line wins, like the core priority
  function automatic logic [GROUP_SEL_W-1:0] first(input logic [GROUP_COUNT-1:0] v);
    first = '0;
    for (int i = GROUP_COUNT - 1; i >= 0; i--)
      if (v[i]) first = i[GROUP_SEL_W-1:0];
  endfunction : first
  // halted debug ignores the global mask but also needs the debug enable
  assign serviceable = debug_halt ?
    (line_flag_reg & core_line_enable_reg & debug_line_enable_reg) :
    (global_mask_bit ? '0 : (line_flag_reg & core_line_enable_reg));
  assign start       = !fetch_wait_reg && (go || serviceable != '0);
  assign pick_line   = first(serviceable);
  // edge latch, so a line still high after ack is not served twice
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      line_flag_reg   <= '0;
      line_q          <= '0;
      global_mask_bit <= 1'b0;
      fetch_wait_reg  <= 1'b0;
      fetch_req       <= 1'b0;
      fetch_group     <= '0;
    end
    else
    begin
      line_q        <= core_interrupt_line;
      line_flag_reg <= line_flag_reg | (core_interrupt_line & ~line_q);
      fetch_req     <= 1'b0;
      if (fetch_valid)
      begin
        fetch_wait_reg  <= 1'b0;
        global_mask_bit <= 1'b0; // handler returns at once
      end
      else if (start)
      begin
        fetch_wait_reg  <= 1'b1;
        global_mask_bit <= 1'b1;
        fetch_req       <= 1'b1;
        fetch_group     <= go ? go_group : pick_line;
        if (!go)
          line_flag_reg[pick_line] <= 1'b0;
      end
    end
  end
endmodule : core_model

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
  import expander_pkg::*;
  logic clk, rst, enable_wr, ctrl_wr, vec_wr, fetch_req, fetch_valid, go, vte, debug_halt;
  logic [SOURCE_COUNT-1:0] src_req, flags, ens;
  logic [SOURCE_COUNT-1:0] periph_flag, periph_en; // peripheral-side flag and enable
  logic [GROUP_COUNT-1:0]  core_line_enable_reg, debug_line_enable_reg;
  localparam logic [VEC_ADDR_W-1:0] vec_waddr_list [3] = '{7'h10, 7'h13, 7'h15};
  logic [PASS_COUNT-1:0]   pass_req, pass_line;
  logic [GROUP_COUNT-1:0]  line, ack_clear, acks;
  logic [GROUP_SEL_W-1:0]  enable_group, fetch_group, go_group;
  logic [7:0]              enable_wdata, ctrl_wdata;
  logic [VEC_ADDR_W-1:0]   vec_waddr;
  logic [VECTOR_WIDTH-1:0] vec_wdata, fetch_vector;
  logic [SRC_SEL_W-1:0]    fetch_source;
  int fails, cmp_count;
  grouped_interrupt_expander DUT (.clk(clk), .rst(rst), .src_req(src_req),
    .pass_req(pass_req), .pass_line(pass_line), .core_interrupt_line(line),
    .enable_wr(enable_wr), .enable_group(enable_group), .enable_wdata(enable_wdata),
    .ack_clear(ack_clear), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .vec_wr(vec_wr), .vec_waddr(vec_waddr), .vec_wdata(vec_wdata),
    .fetch_req(fetch_req), .fetch_group(fetch_group), .fetch_valid(fetch_valid),
    .fetch_vector(fetch_vector), .fetch_source(fetch_source), .group_flag_reg(flags),
    .group_enable_reg(ens), .group_ack_reg(acks), .vector_table_enable(vte));
  core_model core (.clk(clk), .rst(rst), .core_interrupt_line(line), .go(go),
    .go_group(go_group), .fetch_req(fetch_req), .fetch_group(fetch_group),
    .fetch_valid(fetch_valid), .core_line_enable_reg(core_line_enable_reg),
    .debug_line_enable_reg(debug_line_enable_reg), .debug_halt(debug_halt));
  // peripheral raises its request only while its own enable is set
  assign src_req = periph_flag & periph_en;
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // step past an edge so its updates have landed
  task tick;
    @(posedge clk);
    #1;
  endtask : tick
  task chk(input logic [255:0] s, input logic [255:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task conclude;
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // bounded wait for the one-cycle answer pulse
  task wait_valid;
    for (int n = 0; n < 9 && fetch_valid !== 1'b1; n++)
      tick;
    chk(fetch_valid, 1);
  endtask : wait_valid
  // watchdog, far beyond the few dozen cycles the run needs
  initial
  begin
    #20000;
    fails++;
    conclude;
  end
  initial
  begin
    {enable_wr, ctrl_wr, vec_wr, go, debug_halt, pass_req, ack_clear} = '0;
    {enable_group, enable_wdata, ctrl_wdata, vec_waddr, vec_wdata, go_group} = '0;
    {periph_flag, periph_en, debug_line_enable_reg} = '0;
    core_line_enable_reg = 12'hFFF;
    fails = 0;
    cmp_count = 0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk({flags, ens, acks, vte}, 0);
    // fetch while the table is disabled gives zero
    go = 1'b1;
    go_group = 4'h2;
    tick;
    go = 1'b0;
    wait_valid;
    chk(fetch_vector, 0);
    chk(acks, 0);
    // table writes at chosen indices of group 2
    foreach (vec_waddr_list[i])
    begin
      vec_wr = 1'b1;
      vec_waddr = vec_waddr_list[i];
      vec_wdata = 32'hC0DE_0000 | vec_waddr_list[i];
      tick;
    end
    vec_wr = 1'b0;
    ctrl_wr = 1'b1;
    ctrl_wdata = 8'h01;
    tick;
    ctrl_wr = 1'b0;
    chk(vte, 1);
    // events 3 and 5 of group 2, peripheral enable still off
    periph_flag[19] = 1'b1;
    periph_flag[21] = 1'b1;
    tick;
    chk(flags, 0);
    // a late peripheral enable still raises the pending request
    periph_en[19] = 1'b1;
    periph_en[21] = 1'b1;
    tick;
    tick;
    chk(flags, 96'h28 << 16);
    chk(line, 0);
    enable_wr = 1'b1;
    enable_group = 4'h2;
    enable_wdata = 8'h28;
    tick;
    enable_wr = 1'b0;
    chk(ens, 96'h28 << 16);
    tick;
    chk(line, 12'h004);
    wait_valid;
    chk({fetch_vector, fetch_source}, {32'hC0DE_0013, 3'h3});
    chk(flags, 96'h20 << 16);
    chk(acks, 12'h004);
    // software retires the served peripheral event itself
    periph_flag[19] = 1'b0;
    repeat (4) tick;
    chk(line, 0);
    // second service while the core is halted for debug
    debug_halt = 1'b1;
    debug_line_enable_reg = 12'h004;
    ack_clear = 12'h004;
    tick;
    ack_clear = '0;
    wait_valid;
    chk({fetch_vector, fetch_source}, {32'hC0DE_0015, 3'h5});
    chk({flags, acks}, {96'h0, 12'h004});
    debug_halt = 1'b0;
    periph_flag[21] = 1'b0;
    // nothing qualifies: source one answers, its vector rewritten in service
    ack_clear = 12'h004;
    vec_wr = 1'b1;
    vec_waddr = 7'h10;
    vec_wdata = 32'hC0DE_1010;
    tick;
    ack_clear = '0;
    vec_wr = 1'b0;
    go = 1'b1;
    tick;
    go = 1'b0;
    wait_valid;
    chk({fetch_vector, fetch_source}, {32'hC0DE_1010, 3'h0});
    pass_req = 4'hA;
    tick;
    chk(pass_line, 4'hA);
    conclude;
  end
endmodule : tb
